//--- design/lvs_pkg.sv
/*
 Constants shared by the pixel serializer, its receiver model and its bench.
 Assumes one system clock much faster than the pixel clock, so that
 every pixel clock edge is seen and seven serial slots fit in its period.
*/
// How it works
// - Each pixel clock cycle one 28-bit word is captured and sent in that period.
// - The 28 captured bits are spread over exactly four serial data lanes.
// - A fifth lane carries a clock pattern locked and aligned to the pixel clock.
// - Word holds 24 colour bits, line sync, frame sync and data valid, sent every cycle.
// - Every lane sends seven bit slots per pixel clock period.
// - A strap pin chooses rising or falling pixel clock edge for capture.
// - Serial format is identical whichever capture edge is chosen.
// - Powered up but pixel clock missing: all lanes and the clock lane are driven low.
// - No start-up order of power, clock, data or power-down is needed; releasing power-down with the pixel clock high looks like a rising edge.
// - Pixel clock stays within its allowed range; serialization works across it.
// - Clock recovery keeps tracking a slowly modulated spread-spectrum pixel clock.
// - While power-down is low all lane drivers are released.

package lvs_pkg;
   localparam int WORD_BITS = 28;
   localparam int LANES = 4;
   localparam int SLOTS = 7;
   localparam int COLOR_BITS = 24;
   // Bit position of word bit for lane l, slot s is l*SLOTS+s
   localparam int LINE_SYNC_POS = 24;
   localparam int FRAME_SYNC_POS = 25;
   localparam int VALID_POS = 26;
   localparam int SPARE_POS = 27;
   // Clock lane: high for slots 0,1,5,6 of each period, sent slot 0 first
   localparam logic [6:0] CLOCK_PATTERN = 7'h63;
   localparam logic [2:0] SLOT_LAST = 3'h6;
   localparam logic [2:0] SLOT_IDLE = 3'h7;
   // Pixel clock loss: no edge seen for this many system clock cycles
   localparam int LOSS_CYCLES = 32;
   localparam int LOSS_W = 6;
   localparam int CLK_PERIOD_NS = 50;
   localparam int POWER_DOWN_MIN_NS = 1000;
   localparam int POWER_DOWN_MIN_CYCLES =
      (POWER_DOWN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : lvs_pkg

//--- design/lvs_sync.sv
/*
 Two-flop synchroniser for a group of level signals.
 Assumes inputs come from pins or another clock; cleared asynchronously.
*/
`timescale 1ns/1ps
`default_nettype none
module lvs_sync #(
   parameter int WIDTH = 1
) (
   // Clock, enable and clear
   input wire logic clk,
   input wire logic ce,
   input wire logic clear_n,
   // Level in and out
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;

   always_ff @(posedge clk or negedge clear_n) begin
      if (!clear_n) begin
         meta <= '0;
         q <= '0;
      end else if (ce) begin
         meta <= d;
         q <= meta;
      end
   end
endmodule : lvs_sync
`default_nettype wire

//--- design/lvs_serializer.sv
/*
 Pixel serializer: captures a 28-bit pixel word per pixel clock period
 and sends it as seven slots on four data lanes plus a clock lane.
 Assumes clk is fast enough to see each pixel clock level (bench: 50 ns
 against 400 ns); all pins are asynchronous and synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
module lvs_serializer
   import lvs_pkg::*;
#(
   parameter int LOSS_LIMIT = LOSS_CYCLES
) (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   // Pins from the pixel source
   input wire logic pixel_clock_in,
   input wire logic [COLOR_BITS-1:0] color,
   input wire logic line_sync,
   input wire logic frame_sync,
   input wire logic pixel_data_valid,
   input wire logic spare,
   input wire logic sample_rising,
   input wire logic power_down_n,
   // Serial lanes
   output logic [LANES-1:0] lane_data,
   output logic lane_clock,
   output logic lane_oe
);
   // Counter must reach the limit and the limit must exceed one edge gap
   if (LOSS_LIMIT < 2 || LOSS_LIMIT >= (1 << LOSS_W)) begin : g_bad_limit
      $error("LOSS_LIMIT out of range");
   end

   ////////////////////////////////////////////////////////////////////
   // Synchronisers; power-down clears them at once
   logic [WORD_BITS-1:0] pin_word;
   logic [WORD_BITS-1:0] word_s;
   logic [1:0] ctl_s;
   logic pclk_s;
   logic pclk_prev;
   logic pd_s;
   logic pd_live;

   always_comb begin
      pin_word = '0;
      pin_word[COLOR_BITS-1:0] = color;
      pin_word[LINE_SYNC_POS] = line_sync;
      pin_word[FRAME_SYNC_POS] = frame_sync;
      pin_word[VALID_POS] = pixel_data_valid;
      pin_word[SPARE_POS] = spare;
   end

   // Data sees the same two flops as the clock, so it stays aligned
   lvs_sync #(.WIDTH(WORD_BITS)) u_word (
      .clk(clk), .ce(ce), .clear_n(power_down_n), .d(pin_word), .q(word_s)
   );
   lvs_sync #(.WIDTH(2)) u_ctl (
      .clk(clk), .ce(ce), .clear_n(power_down_n),
      .d({pixel_clock_in, sample_rising}), .q(ctl_s)
   );
   lvs_sync #(.WIDTH(1)) u_pd (
      .clk(clk), .ce(ce), .clear_n(power_down_n), .d(1'b1), .q(pd_s)
   );
   assign pclk_s = ctl_s[1];
   // Release of power-down waits two clocks; release with the pixel clock pin high looks like a rising edge
   assign pd_live = pd_s & ~reset;

   ////////////////////////////////////////////////////////////////////
   // Edge detect on the chosen pixel clock edge
   logic take;

   always_ff @(posedge clk or negedge power_down_n) begin
      if (!power_down_n) begin
         pclk_prev <= 1'b0;
      end else if (ce) begin
         // Tracks the pin through reset too, so release with the pin high
         // does not look like a rising edge
         pclk_prev <= pclk_s;
      end
   end

   // Either edge starts the same slot sequence
   assign take = pd_live &
      (ctl_s[0] ? (pclk_s & ~pclk_prev) : (~pclk_s & pclk_prev));

   ////////////////////////////////////////////////////////////////////
   // Clock loss detector
   logic [LOSS_W-1:0] idle_count;
   logic lost;

   always_ff @(posedge clk or negedge power_down_n) begin
      if (!power_down_n) begin
         idle_count <= '0;
         lost <= 1'b1;
      end else if (ce) begin
         if (!pd_live) begin
            idle_count <= '0;
            lost <= 1'b1;
         end else if (take) begin
            idle_count <= '0;
            lost <= 1'b0;
         end else if (idle_count == LOSS_W'(LOSS_LIMIT - 1)) begin
            lost <= 1'b1;
         end else begin
            idle_count <= idle_count + LOSS_W'(1);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Capture and slot sequencing
   logic [WORD_BITS-1:0] held;
   logic [2:0] slot;

   // Each edge retriggers the sequence, so a slowly drifting period
   // is followed without any loop state
   always_ff @(posedge clk or negedge power_down_n) begin
      if (!power_down_n) begin
         held <= '0;
         slot <= SLOT_IDLE;
      end else if (ce) begin
         if (!pd_live) begin
            held <= '0;
            slot <= SLOT_IDLE;
         end else if (take) begin
            held <= word_s;
            slot <= '0;
         end else if (slot != SLOT_IDLE) begin
            slot <= (slot == SLOT_LAST) ? SLOT_IDLE : slot + 3'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Lane outputs
   genvar l;
   generate
      for (l = 0; l < LANES; l++) begin : g_lane
         always_ff @(posedge clk or negedge power_down_n) begin
            if (!power_down_n) begin
               lane_data[l] <= 1'b0;
            end else if (ce) begin
               if (!pd_live || lost || slot == SLOT_IDLE) begin
                  lane_data[l] <= 1'b0;
               end else begin
                  lane_data[l] <= held[l*SLOTS + int'(slot)];
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge power_down_n) begin
      if (!power_down_n) begin
         lane_clock <= 1'b0;
         lane_oe <= 1'b0;
      end else if (ce) begin
         lane_oe <= pd_live;
         if (!pd_live || lost || slot == SLOT_IDLE) begin
            lane_clock <= 1'b0;
         end else begin
            lane_clock <= CLOCK_PATTERN[SLOT_LAST - slot];
         end
      end
   end
endmodule : lvs_serializer
`default_nettype wire

//--- test/lvs_serializer_checker.sv
/* Port assertions for lvs_serializer; assumes clk sees every pixel clock level. */
`timescale 1ns/1ps
`default_nettype none
module lvs_serializer_checker #(
   parameter int LOSS_LIMIT = 32
) (
   // Clock, reset, pins in
   input wire logic clk,
   input wire logic reset,
   input wire logic pixel_clock_in,
   input wire logic sample_rising,
   input wire logic power_down_n,
   // Lanes out
   input wire logic [3:0] lane_data,
   input wire logic lane_clock,
   input wire logic lane_oe
);
   logic [2:0] low_run = 3'h7;
   logic [7:0] still = 8'h00;
   // Three low slots before a rise mark slot 5, not a frame start
   always_ff @(posedge clk) begin
      low_run <= lane_clock ? 3'h0 : low_run + {2'h0, low_run != 3'h7};
      still <= $changed(pixel_clock_in) ? 8'h00 : still + {7'h00, still != 8'hFF};
   end
   sequence clk_head;
      lane_clock [*2] ##1 !lane_clock [*3];
   endsequence
   sequence clk_tail;
      lane_clock [*2] ##1 !lane_clock;
   endsequence
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   a_pd_float: assert property (
      !power_down_n |-> !lane_oe && lane_data == 4'h0 && !lane_clock) else $error("lanes driven");
   a_pd_release: assert property ($rose(power_down_n) |-> !lane_oe [*2] ##[1:2] lane_oe)
      else $error("enable timing after power-up");
   a_reset_quiet: assert property (disable iff (!power_down_n)
      reset |=> !lane_oe && lane_data == 4'h0 && !lane_clock) else $error("lanes after reset");
   a_clock_frame: assert property (disable iff (reset || !power_down_n)
      $rose(lane_clock) && low_run != 3'h3 |-> clk_head ##1 clk_tail)
      else $error("clock lane pattern");
   a_loss_quiet: assert property (
      still >= LOSS_LIMIT + 4 |-> lane_data == 4'h0 && !lane_clock) else $error("lanes on loss");
   a_data_oe: assert property (lane_data != 4'h0 |-> lane_oe)
      else $error("data while released");
   a_edge_frame: assert property (disable iff (reset || !power_down_n)
      (sample_rising ? $rose(pixel_clock_in) : $fell(pixel_clock_in)) |-> ##[2:4] $rose(lane_clock))
      else $error("no frame after edge");
   a_oe_holds: assert property (disable iff (reset || !power_down_n) lane_oe |=> lane_oe)
      else $error("enable dropped");
endmodule : lvs_serializer_checker
bind lvs_serializer lvs_serializer_checker #(.LOSS_LIMIT(LOSS_LIMIT)) chk (.clk(clk),
   .reset(reset), .pixel_clock_in(pixel_clock_in), .sample_rising(sample_rising),
   .power_down_n(power_down_n), .lane_data(lane_data), .lane_clock(lane_clock), .lane_oe(lane_oe));
`default_nettype wire

//--- test/lvs_rx_model.sv
/* Display-side receiver: rebuilds words from the lanes; needs slot-rate clk. */
`timescale 1ns/1ps
`default_nettype none
module lvs_rx_model
   import lvs_pkg::*;
(
   // Lanes in
   input wire logic clk,
   input wire logic [LANES-1:0] lane_data,
   input wire logic lane_clock,
   input wire logic lane_oe,
   // Word out
   output logic [WORD_BITS-1:0] word,
   output logic got
);
   logic [2:0] slot = SLOT_IDLE;
   logic [2:0] s;
   logic [WORD_BITS-1:0] acc;
   // Same framing for either strap: no translation on this side
   always @(posedge clk) begin
      got <= 1'b0;
      s = (slot == SLOT_IDLE) ? 3'h0 : slot;
      if (!lane_oe) slot <= SLOT_IDLE;
      else if (slot != SLOT_IDLE || lane_clock) begin
         for (int l = 0; l < LANES; l++) acc[l*SLOTS+s] = lane_data[l];
         slot <= (s == SLOT_LAST) ? SLOT_IDLE : s + 3'h1;
         word <= acc;
         got <= (s == SLOT_LAST);
      end
   end
endmodule : lvs_rx_model
`default_nettype wire

//--- test/lvs_serializer_tb.sv
/* Bench for lvs_serializer: drives the source pins, checks rebuilt words. */
`timescale 1ns/1ps
`default_nettype none
module lvs_serializer_tb
   import lvs_pkg::*;
;
   logic clk = 1'b0, reset = 1'b1, pclk = 1'b0, strap = 1'b1, pd_n = 1'b1, lane_clock, lane_oe, got;
   logic [WORD_BITS-1:0] w = 28'h0000000, rx_word, exp_q[$];
   logic [LANES-1:0] lane_data;
   int errors = 0, n_compared = 0, n_rx = 0;
   always #25 clk = ~clk;
   lvs_serializer #(.LOSS_LIMIT(10)) uut (.clk(clk), .reset(reset), .ce(1'b1),
      .pixel_clock_in(pclk), .color(w[COLOR_BITS-1:0]), .line_sync(w[LINE_SYNC_POS]),
      .frame_sync(w[FRAME_SYNC_POS]), .pixel_data_valid(w[VALID_POS]), .spare(w[SPARE_POS]),
      .sample_rising(strap), .power_down_n(pd_n), .lane_data(lane_data),
      .lane_clock(lane_clock), .lane_oe(lane_oe));
   lvs_rx_model rx (.clk(clk), .lane_data(lane_data), .lane_clock(lane_clock),
      .lane_oe(lane_oe), .word(rx_word), .got(got));
   task automatic check(input string what, input logic [WORD_BITS-1:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   always @(posedge clk) if (got === 1'b1) begin
      n_rx++;
      check("word", rx_word, exp_q.pop_front());
   end
   task automatic complete_run;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : complete_run
   // Word changes 4 clk before the chosen edge so the synchroniser sees it settled
   task automatic send(input logic rise, input int n);
      int start;
      logic [WORD_BITS-1:0] v;
      start = n_rx;
      strap <= rise;
      repeat (4) @(posedge clk);
      for (int i = 0; i < n; i++) begin
         v = 28'h5A3C96E ^ 28'(i * 32'h1234567);
         exp_q.push_back(v);
         w <= v;
         pclk <= !rise;
         repeat (4) @(posedge clk);
         pclk <= rise;
         repeat (4) @(posedge clk);
      end
      repeat (16) @(posedge clk);
      check("frames", 28'(n_rx - start), 28'(n));
      check("idle", 28'({lane_oe, lane_clock, lane_data}), 28'h0000020);
      $display("send done strap %0b", rise);
   endtask : send
   task automatic power_cycle;
      pd_n <= 1'b0;
      repeat (POWER_DOWN_MIN_CYCLES) @(posedge clk);
      check("parked", 28'({lane_oe, lane_clock, lane_data}), 28'h0000000);
      pd_n <= 1'b1;
      send(1'b1, 3);
   endtask : power_cycle
   initial begin
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      send(1'b1, 6);
      send(1'b0, 6);
      power_cycle();
      complete_run();
   end
   initial begin
      repeat (2000) @(posedge clk);
      errors++;
      complete_run();
   end
endmodule : lvs_serializer_tb
`default_nettype wire
